// ### tpb_params.svh
// Purpose: constants for the timer, pwm, buzzer and converter block
// Assumes: clk_in is the 25 MHz system clock; the instruction clock is half of it
// Notes: F-plane registers are read/write except the read-only converter result, R-plane registers are write-only
//
// Notes on behaviour
// - dog and wakeup share one timer, 13-100ms
// - dog clear instruction restarts the shared timer
// - config bit 6: reset on overflow, else wakeup
// - timer runs always; stops when both uses off
// - config bit 7 enables external pin reset
// - low voltage field: 11/01 on, 00 off, 10 bad
// - sleep stops clock and peripherals, not timer
// - reset or enabled wake interrupt leaves sleep
// - first timer: 8-bit read/write, wraps on overflow
// - first prescaler fed by instruction clock or pin
// - first timer rollover sets its pending flag
// - second timer reloads offset on rollover
// - second rollover sets flag, toggles match output
// - pwm: 1024 steps, 256 clock period
// - pwm goes low when counter matches duty top
// - low duty bits delay rise by one clock
// - start bit begins conversion, cleared when done
// - zero in pin type mask means analog
// - buzzer square wave needs count and pin enable
// - tone = inst clock / prescale / (period+1)
// - timer prescale codes 0..8 divide 1..256
// - buzzer prescale codes divide 4, 8, 16, 32
// - dog period codes 13/25/50/100ms, reset 11
`ifndef TPB_PARAMS_SVH
`define TPB_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TPB_CLK_KHZ 25000
`define TPB_DOG_T0_MS 13
`define TPB_DOG_T1_MS 25
`define TPB_DOG_T2_MS 50
`define TPB_DOG_T3_MS 100

// ----------------------------------------------------------------
// F-plane offsets
// ----------------------------------------------------------------
`define TPB_F_FIRST_COUNTER_VALUE 8'h01
`define TPB_F_FLAGS 8'h09
`define TPB_F_TIMER1 8'h0a
`define TPB_F_PWM0_HI 8'h0c
`define TPB_F_PWM0_LO 8'h0d
`define TPB_F_PWM1_HI 8'h0e
`define TPB_F_PWM1_LO 8'h0f
`define TPB_F_CONV_HI 8'h10
`define TPB_F_CONV_CTL 8'h11

// ----------------------------------------------------------------
// R-plane offsets and reset values
// ----------------------------------------------------------------
`define TPB_R_T0CFG 8'h02
`define TPB_R_SLEEP 8'h03
`define TPB_R_DOGCLR 8'h04
`define TPB_R_OUTEN 8'h0b
`define TPB_R_T1CFG 8'h0c
`define TPB_R_RELOAD 8'h0d
`define TPB_R_IRQEN 8'h0e
`define TPB_R_TONE 8'h10
`define TPB_R_PINTYPE 8'h12
`define TPB_OUTEN_RST 8'h03
`define TPB_PINTYPE_RST 8'hff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TPB_FLAG_T1 5
`define TPB_FLAG_T0 4
`define TPB_FLAG_WK 3
`define TPB_CONV_START 3
`define TPB_CFG_PINRST 7
`define TPB_CFG_DOGRST 6
`define TPB_OUTEN_TONE 7
`define TPB_OUTEN_PWM0 6
`define TPB_OUTEN_PWM1 5
`define TPB_OUTEN_T1 2
`define TPB_T0_EDGE 5
`define TPB_T0_SRC 4
`define TPB_T1CFG_TONE 7

`endif

// ### tpb_pkg.sv
// Purpose: shared types of the timer, pwm, buzzer and converter block
// Assumes: nothing beyond the params header
// Notes: constants live in tpb_params.svh
`default_nettype none
package tpb_pkg;
	// power state of the peripheral domain
	typedef enum logic {TPB_RUN, TPB_SLEEP} tpb_pwr_t;
	// converter handshake state
	typedef enum logic {TPB_CONV_IDLE, TPB_CONV_BUSY} tpb_conv_t;
endpackage : tpb_pkg
`default_nettype wire

// ### tpb_pwm_if.sv
// Purpose: carrier between the block top and one pwm channel
// Assumes: one clock domain
// Notes: wave is registered inside the channel
`timescale 1ns/100ps
`default_nettype none
interface tpb_pwm_if;
	logic [7:0] duty_hi;
	logic [1:0] duty_lo;
	logic pin_en;
	logic run;
	logic wave;
	modport ctrl (output duty_hi, output duty_lo, output pin_en, output run, input wave);
	modport chan (input duty_hi, input duty_lo, input pin_en, input run, output wave);
endinterface : tpb_pwm_if
`default_nettype wire

// ### tpb_pwm_chan.sv
// Purpose: one 8+2 bit pwm channel on the system clock
// Assumes: duty fields come from registers in the top
// Notes: the low bits stretch the rise over a group of four periods
`timescale 1ns/100ps
`default_nettype none
module tpb_pwm_chan (
	input wire logic clk_in,
	input wire logic reset_in,
	tpb_pwm_if.chan bus
);
	logic [7:0] base_q;
	logic [1:0] frame_q;
	logic wave_q;
	logic out_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// the delayed rise loses one clock of high time, so fewer delayed
	// periods per group of four means a wider average pulse
	wire delay_w = frame_q >= bus.duty_lo;
	wire match_w = base_q == bus.duty_hi;
	wire rise_w = (base_q == 8'h00 && !delay_w) || (base_q == 8'h01 && delay_w);
	wire wave_d = match_w ? 1'b0 : (rise_w ? 1'b1 : wave_q);

	// base counter wraps every 256 clocks; frame counts periods
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			base_q <= 8'h00;
			frame_q <= 2'h0;
			wave_q <= 1'b0;
			out_q <= 1'b0;
		end else if (bus.run) begin
			base_q <= base_q + 8'h01;
			if (base_q == 8'hff) begin
				frame_q <= frame_q + 2'h1;
			end
			wave_q <= wave_d;
			out_q <= wave_d & bus.pin_en;
		end
	end

	assign bus.wave = out_q;
endmodule : tpb_pwm_chan
`default_nettype wire

// ### tpb_periph.sv
// Purpose: timers, watchdog/wakeup, pwm, buzzer and converter control
// Assumes: CPU register strobes are on clk_in; config word is stable at reset
// Notes: sleep gates the instruction tick; the dog timer keeps running
`include "tpb_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tpb_periph #(
	parameter int unsigned DOG_CYC0 = `TPB_DOG_T0_MS * `TPB_CLK_KHZ,
	parameter int unsigned DOG_CYC1 = `TPB_DOG_T1_MS * `TPB_CLK_KHZ,
	parameter int unsigned DOG_CYC2 = `TPB_DOG_T2_MS * `TPB_CLK_KHZ,
	parameter int unsigned DOG_CYC3 = `TPB_DOG_T3_MS * `TPB_CLK_KHZ
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [13:0] config_word_in,
	input wire logic [7:0] f_addr_in,
	input wire logic f_wr_in,
	input wire logic [7:0] f_wdata_in,
	output logic [7:0] f_rdata_out,
	input wire logic [7:0] r_addr_in,
	input wire logic r_wr_in,
	input wire logic [7:0] r_wdata_in,
	input wire logic first_timer_count_pin_in,
	input wire logic ext_reset_pin_n_in,
	input wire logic [2:0] ext_irq_pending_in,
	input wire logic conv_done_in,
	input wire logic [11:0] conv_result_in,
	output logic chip_reset_out,
	output logic sleep_out,
	output logic irq_out,
	output logic second_timer_toggle_out,
	output logic tone_out,
	output logic pwm0_out,
	output logic pwm1_out,
	output logic conv_start_out,
	output logic [2:0] conv_channel_out,
	output logic conv_clk_tick_out,
	output logic [7:0] conv_pin_type_mask_out,
	output logic lvr_enable_out,
	output logic lvr_level_sel_out,
	output logic lvr_invalid_out,
	output logic [1:0] clock_source_select_out
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true once per 2^code source ticks; codes above 8 act as 256
	function automatic logic psc_hit(input logic [7:0] cnt, input logic [3:0] code);
		logic [7:0] mask;
		mask = (code >= 4'd8) ? 8'hff : 8'((9'h001 << code) - 9'h001);
		return (cnt & mask) == mask;
	endfunction : psc_hit

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [13:0] cfg_q;
	logic cfg_taken_q;
	tpb_pkg::tpb_pwr_t pwr_q;
	tpb_pkg::tpb_conv_t conv_q;
	logic inst_q;
	logic t0s1_q, t0s2_q, t0s3_q;
	logic rs1_q, rs2_q;
	logic [7:0] t0cfg_q, outen_q, t1cfg_q, reload_q, irqen_q, tone_cfg_q, pintype_q;
	logic [7:0] t0_q, t1_q, t0psc_q, t1psc_q, tpsc_q, cdiv_q;
	logic [5:0] tcnt_q;
	logic tone_q, t1tgl_q;
	logic [2:0] flags_q;
	logic [21:0] dog_q;
	logic [7:0] pwm0_hi_q, pwm1_hi_q;
	logic [1:0] pwm0_lo_q, pwm1_lo_q;
	logic [2:0] chan_q;
	logic [11:0] result_q;
	logic [7:0] rdata_q;
	logic creset_q, irq_q, tone_pin_q, t1_pin_q, cstart_q, cclk_q;

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	wire fw_t0 = f_wr_in && f_addr_in == `TPB_F_FIRST_COUNTER_VALUE;
	wire fw_flags = f_wr_in && f_addr_in == `TPB_F_FLAGS;
	wire fw_t1 = f_wr_in && f_addr_in == `TPB_F_TIMER1;
	wire fw_conv = f_wr_in && f_addr_in == `TPB_F_CONV_CTL;
	wire rw_sleep = r_wr_in && r_addr_in == `TPB_R_SLEEP;
	wire rw_dogclr = r_wr_in && r_addr_in == `TPB_R_DOGCLR;

	// ----------------------------------------------------------------
	// config word fields
	// ----------------------------------------------------------------
	wire cfg_dog_rst = cfg_q[`TPB_CFG_DOGRST];
	wire cfg_pin_rst = cfg_q[`TPB_CFG_PINRST];
	wire [1:0] cfg_lvr = cfg_q[11:10];

	// ----------------------------------------------------------------
	// clock ticks
	// ----------------------------------------------------------------
	// peripherals see no tick while asleep
	wire run_w = pwr_q == tpb_pkg::TPB_RUN;
	wire inst_tick = inst_q & run_w;
	wire t0_edge = t0cfg_q[`TPB_T0_EDGE] ? (t0s3_q & ~t0s2_q) : (~t0s3_q & t0s2_q);
	wire t0_src = run_w & (t0cfg_q[`TPB_T0_SRC] ? t0_edge : inst_tick);
	wire t0_step = t0_src & psc_hit(t0psc_q, t0cfg_q[3:0]);
	wire t1_step = inst_tick & psc_hit(t1psc_q, t1cfg_q[3:0]);
	wire t0_roll = t0_step && t0_q == 8'hff && !fw_t0;
	wire t1_roll = t1_step && t1_q == 8'hff && !fw_t1;

	// ----------------------------------------------------------------
	// watchdog / wakeup decode
	// ----------------------------------------------------------------
	wire wk_ie = irqen_q[`TPB_FLAG_WK];
	wire dog_run = cfg_dog_rst | wk_ie;
	wire [21:0] dog_lim = (outen_q[1:0] == 2'b00) ? 22'(DOG_CYC0 - 1) :
		(outen_q[1:0] == 2'b01) ? 22'(DOG_CYC1 - 1) :
		(outen_q[1:0] == 2'b10) ? 22'(DOG_CYC2 - 1) : 22'(DOG_CYC3 - 1);
	wire dog_ovf = dog_run && dog_q == dog_lim;
	wire wk_set = dog_ovf & ~cfg_dog_rst;
	wire wake = (flags_q[0] & wk_ie) | (|(ext_irq_pending_in & irqen_q[2:0]));

	// ----------------------------------------------------------------
	// buzzer and converter clock decode
	// ----------------------------------------------------------------
	wire tone_en = t1cfg_q[`TPB_T1CFG_TONE];
	// half the prescale ratio, since a full wave is two toggles
	wire tone_tick = inst_tick & tone_en & psc_hit(tpsc_q, {2'b00, tone_cfg_q[7:6]} + 4'd1);
	wire tone_wrap = tcnt_q == tone_cfg_q[5:0];
	wire cclk_tick = inst_tick & psc_hit(cdiv_q, 4'd7 - {1'b0, t1cfg_q[6:4]});
	wire start_req = fw_conv && f_wdata_in[`TPB_CONV_START];

	// ----------------------------------------------------------------
	// F-plane read selection
	// ----------------------------------------------------------------
	wire [7:0] rd_mux = (f_addr_in == `TPB_F_FIRST_COUNTER_VALUE) ? t0_q :
		(f_addr_in == `TPB_F_FLAGS) ? {2'b00, flags_q, 3'b000} :
		(f_addr_in == `TPB_F_TIMER1) ? t1_q :
		(f_addr_in == `TPB_F_PWM0_HI) ? pwm0_hi_q :
		(f_addr_in == `TPB_F_PWM0_LO) ? {pwm0_lo_q, 6'h00} :
		(f_addr_in == `TPB_F_PWM1_HI) ? pwm1_hi_q :
		(f_addr_in == `TPB_F_PWM1_LO) ? {pwm1_lo_q, 6'h00} :
		(f_addr_in == `TPB_F_CONV_HI) ? result_q[11:4] :
		(f_addr_in == `TPB_F_CONV_CTL) ?
			{result_q[3:0], conv_q == tpb_pkg::TPB_CONV_BUSY, chan_q} : 8'h00;

	// ----------------------------------------------------------------
	// config capture and pin synchronisers
	// ----------------------------------------------------------------
	// config is taken once after release so that reset holds constants only
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_q <= 14'h0000;
			cfg_taken_q <= 1'b0;
		end else if (!cfg_taken_q) begin
			cfg_q <= config_word_in;
			cfg_taken_q <= 1'b1;
		end
	end

	// two stages before any logic; third stage for edge detect
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			{t0s1_q, t0s2_q, t0s3_q} <= 3'b000;
			{rs1_q, rs2_q} <= 2'b11;
		end else begin
			{t0s1_q, t0s2_q, t0s3_q} <= {first_timer_count_pin_in, t0s1_q, t0s2_q};
			{rs1_q, rs2_q} <= {ext_reset_pin_n_in, rs1_q};
		end
	end

	// ----------------------------------------------------------------
	// R-plane write-only registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			t0cfg_q <= 8'h00;
			outen_q <= `TPB_OUTEN_RST;
			t1cfg_q <= 8'h00;
			reload_q <= 8'h00;
			irqen_q <= 8'h00;
			tone_cfg_q <= 8'h00;
			pintype_q <= `TPB_PINTYPE_RST;
		end else if (r_wr_in) begin
			if (r_addr_in == `TPB_R_T0CFG) t0cfg_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_OUTEN) outen_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_T1CFG) t1cfg_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_RELOAD) reload_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_IRQEN) irqen_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_TONE) tone_cfg_q <= r_wdata_in;
			if (r_addr_in == `TPB_R_PINTYPE) pintype_q <= r_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------
	// sleep entry and wake; a reset ends sleep through reset_in
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pwr_q <= tpb_pkg::TPB_RUN;
		end else begin
			unique case (pwr_q)
				tpb_pkg::TPB_RUN: if (rw_sleep) pwr_q <= tpb_pkg::TPB_SLEEP;
				tpb_pkg::TPB_SLEEP: if (wake) pwr_q <= tpb_pkg::TPB_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// instruction tick and prescalers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			inst_q <= 1'b0;
			t0psc_q <= 8'h00;
			t1psc_q <= 8'h00;
			cdiv_q <= 8'h00;
		end else begin
			inst_q <= run_w ? ~inst_q : inst_q;
			if (t0_src) t0psc_q <= t0psc_q + 8'h01;
			if (inst_tick) t1psc_q <= t1psc_q + 8'h01;
			if (inst_tick) cdiv_q <= cdiv_q + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// first and second timers
	// ----------------------------------------------------------------
	// a software write wins over a step in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			t0_q <= 8'h00;
			t1_q <= 8'h00;
			t1tgl_q <= 1'b0;
		end else begin
			if (fw_t0) t0_q <= f_wdata_in;
			else if (t0_step) t0_q <= t0_q + 8'h01;
			if (fw_t1) t1_q <= f_wdata_in;
			else if (t1_roll) t1_q <= reload_q;
			else if (t1_step) t1_q <= t1_q + 8'h01;
			if (t1_roll) t1tgl_q <= ~t1tgl_q;
		end
	end

	// ----------------------------------------------------------------
	// pending flags: hardware set wins over a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			flags_q <= 3'b000;
		end else begin
			flags_q[2] <= t1_roll | (flags_q[2] & ~(fw_flags & ~f_wdata_in[`TPB_FLAG_T1]));
			flags_q[1] <= t0_roll | (flags_q[1] & ~(fw_flags & ~f_wdata_in[`TPB_FLAG_T0]));
			flags_q[0] <= wk_set | (flags_q[0] & ~(fw_flags & ~f_wdata_in[`TPB_FLAG_WK]));
		end
	end

	// ----------------------------------------------------------------
	// watchdog / wakeup timer
	// ----------------------------------------------------------------
	// not gated by sleep, so it can wake the core
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			dog_q <= 22'h000000;
		end else if (rw_dogclr || !dog_run || dog_ovf) begin
			dog_q <= 22'h000000;
		end else begin
			dog_q <= dog_q + 22'h000001;
		end
	end

	// ----------------------------------------------------------------
	// buzzer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tpsc_q <= 8'h00;
			tcnt_q <= 6'h00;
			tone_q <= 1'b0;
		end else if (!tone_en) begin
			tpsc_q <= 8'h00;
			tcnt_q <= 6'h00;
			tone_q <= 1'b0;
		end else begin
			if (inst_tick) tpsc_q <= tpsc_q + 8'h01;
			if (tone_tick) begin
				tcnt_q <= tone_wrap ? 6'h00 : tcnt_q + 6'h01;
				if (tone_wrap) tone_q <= ~tone_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// pwm duty registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			{pwm0_hi_q, pwm0_lo_q, pwm1_hi_q, pwm1_lo_q} <= 20'h00000;
		end else if (f_wr_in) begin
			if (f_addr_in == `TPB_F_PWM0_HI) pwm0_hi_q <= f_wdata_in;
			if (f_addr_in == `TPB_F_PWM0_LO) pwm0_lo_q <= f_wdata_in[7:6];
			if (f_addr_in == `TPB_F_PWM1_HI) pwm1_hi_q <= f_wdata_in;
			if (f_addr_in == `TPB_F_PWM1_LO) pwm1_lo_q <= f_wdata_in[7:6];
		end
	end

	// ----------------------------------------------------------------
	// converter handshake
	// ----------------------------------------------------------------
	// a start written with a done in flight wins and begins anew
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			conv_q <= tpb_pkg::TPB_CONV_IDLE;
			chan_q <= 3'h0;
			result_q <= 12'h000;
		end else begin
			if (fw_conv) chan_q <= f_wdata_in[2:0];
			unique case (conv_q)
				tpb_pkg::TPB_CONV_IDLE: if (start_req) conv_q <= tpb_pkg::TPB_CONV_BUSY;
				tpb_pkg::TPB_CONV_BUSY: if (conv_done_in && !start_req) begin
					conv_q <= tpb_pkg::TPB_CONV_IDLE;
				end
			endcase
			if (conv_q == tpb_pkg::TPB_CONV_BUSY && conv_done_in) result_q <= conv_result_in;
		end
	end

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_q <= 8'h00;
			creset_q <= 1'b0;
			irq_q <= 1'b0;
			tone_pin_q <= 1'b0;
			t1_pin_q <= 1'b0;
			cstart_q <= 1'b0;
			cclk_q <= 1'b0;
		end else begin
			rdata_q <= rd_mux;
			creset_q <= (dog_ovf & cfg_dog_rst) | (cfg_pin_rst & ~rs2_q);
			irq_q <= |({flags_q, ext_irq_pending_in} & irqen_q[5:0]);
			tone_pin_q <= tone_q & tone_en & outen_q[`TPB_OUTEN_TONE];
			t1_pin_q <= t1tgl_q & outen_q[`TPB_OUTEN_T1];
			cstart_q <= start_req;
			cclk_q <= cclk_tick;
		end
	end

	// ----------------------------------------------------------------
	// pwm channels
	// ----------------------------------------------------------------
	tpb_pwm_if pwm0_if ();
	tpb_pwm_if pwm1_if ();
	assign pwm0_if.duty_hi = pwm0_hi_q;
	assign pwm0_if.duty_lo = pwm0_lo_q;
	assign pwm0_if.pin_en = outen_q[`TPB_OUTEN_PWM0];
	assign pwm0_if.run = run_w;
	assign pwm1_if.duty_hi = pwm1_hi_q;
	assign pwm1_if.duty_lo = pwm1_lo_q;
	assign pwm1_if.pin_en = outen_q[`TPB_OUTEN_PWM1];
	assign pwm1_if.run = run_w;

	tpb_pwm_chan u_pwm0 (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.bus(pwm0_if.chan)
	);

	tpb_pwm_chan u_pwm1 (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.bus(pwm1_if.chan)
	);

	// ----------------------------------------------------------------
	// port drive; low-voltage and clock fields are held config bits
	// ----------------------------------------------------------------
	assign f_rdata_out = rdata_q;
	assign chip_reset_out = creset_q;
	assign sleep_out = pwr_q == tpb_pkg::TPB_SLEEP;
	assign irq_out = irq_q;
	assign second_timer_toggle_out = t1_pin_q;
	assign tone_out = tone_pin_q;
	assign pwm0_out = pwm0_if.wave;
	assign pwm1_out = pwm1_if.wave;
	assign conv_start_out = cstart_q;
	assign conv_channel_out = chan_q;
	assign conv_clk_tick_out = cclk_q;
	assign conv_pin_type_mask_out = pintype_q;
	assign lvr_enable_out = cfg_lvr[0];
	assign lvr_level_sel_out = cfg_lvr == 2'b01;
	assign lvr_invalid_out = cfg_lvr == 2'b10;
	assign clock_source_select_out = cfg_q[9:8];
endmodule : tpb_periph
`default_nettype wire

// ### tpb_conv_model.sv
// Purpose: stand-in converter
// Assumes: start is a one-cycle pulse
// Notes: result churns when not offered
`timescale 1ns/100ps
`default_nettype none
module tpb_conv_model #(
	parameter int LAT = 12
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic conv_start_in,
	input wire logic [2:0] conv_channel_in,
	output logic conv_done_out,
	output logic [11:0] conv_result_out
);
	int cnt_q;
	// result carries the channel, so a wrong mux select shows in the read-back
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_q <= 0;
			conv_done_out <= 1'b0;
			conv_result_out <= 12'h000;
		end else begin
			cnt_q <= conv_start_in ? LAT : (cnt_q != 0 ? cnt_q - 1 : 0);
			conv_done_out <= (cnt_q == 1);
			conv_result_out <= (cnt_q == 1) ? {conv_channel_in, 9'h0a5} : ~conv_result_out;
		end
	end
endmodule : tpb_conv_model
`default_nettype wire

// ### tpb_periph_asserts.sv
// Purpose: port checks of tpb_periph
// Assumes: config word changes only in reset
// Notes: bound to every instance
`timescale 1ns/100ps
`default_nettype none
module tpb_periph_chk (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [13:0] config_word_in,
	input wire logic [7:0] f_addr_in,
	input wire logic f_wr_in,
	input wire logic [7:0] f_wdata_in,
	input wire logic [7:0] f_rdata_out,
	input wire logic [7:0] r_addr_in,
	input wire logic r_wr_in,
	input wire logic [7:0] r_wdata_in,
	input wire logic ext_reset_pin_n_in,
	input wire logic conv_done_in,
	input wire logic chip_reset_out,
	input wire logic sleep_out,
	input wire logic conv_start_out,
	input wire logic [7:0] conv_pin_type_mask_out,
	input wire logic lvr_enable_out,
	input wire logic lvr_invalid_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// converter handshake as seen from the bus
	start_pulse_a: assert property (f_wr_in && f_addr_in == 8'h11 && f_wdata_in[3] |=> conv_start_out)
		else $error("no start pulse");
	start_single_a: assert property (conv_start_out |=> !conv_start_out)
		else $error("long start");
	busy_read_a: assert property (conv_start_out && f_addr_in == 8'h11 |=> f_rdata_out[3])
		else $error("busy not set");
	done_clear_a: assert property (conv_done_in ##1 f_addr_in == 8'h11 && !f_wr_in |=> !f_rdata_out[3])
		else $error("busy stuck");
	// power, reset and configuration decode
	sleep_entry_a: assert property (r_wr_in && r_addr_in == 8'h03 |=> sleep_out)
		else $error("no sleep");
	pin_reset_a: assert property ((config_word_in[7] && !ext_reset_pin_n_in) [*5] |-> chip_reset_out)
		else $error("no pin reset");
	lvr_decode_a: assert property (!$past(reset_in, 2) |-> lvr_enable_out == config_word_in[10] && lvr_invalid_out == (config_word_in[11:10] == 2'b10))
		else $error("bad lvr decode");
	mask_write_a: assert property (r_wr_in && r_addr_in == 8'h12 |=> conv_pin_type_mask_out == $past(r_wdata_in))
		else $error("mask not written");
	cover property (conv_start_out);
	cover property ($rose(sleep_out));
	cover property ($rose(chip_reset_out));
endmodule : tpb_periph_chk
bind tpb_periph tpb_periph_chk u_tpb_periph_chk (.*);
`default_nettype wire

// ### testbench.sv
// Purpose: register-level test of tpb_periph
// Assumes: dog limits shrunk to 20/30/40/50 clocks
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_in = 1'b0, reset_in = 1'b0, f_wr_in = 1'b0, r_wr_in = 1'b0, conv_done_in, t;
	logic first_timer_count_pin_in = 1'b0, ext_reset_pin_n_in = 1'b1, chip_reset_out;
	logic sleep_out, second_timer_toggle_out, tone_out, pwm0_out, conv_start_out, lvr_invalid_out;
	logic [13:0] config_word_in = 14'h0400;
	logic [7:0] f_addr_in = 8'h00, f_wdata_in = 8'h00, r_addr_in = 8'h00, r_wdata_in = 8'h00;
	logic [7:0] f_rdata_out, conv_pin_type_mask_out, d, e;
	logic [2:0] ext_irq_pending_in = 3'b000, conv_channel_out;
	logic [11:0] conv_result_in;
	logic irq_out, pwm1_out, conv_clk_tick_out, lvr_enable_out, lvr_level_sel_out;
	logic [1:0] clock_source_select_out;
	int fails = 0, n_tests = 0, n, k;
	tpb_periph #(.DOG_CYC0(20), .DOG_CYC1(30), .DOG_CYC2(40), .DOG_CYC3(50)) u_tpb_periph (.*);
	tpb_conv_model u_tpb_conv_model (.clk_in(clk_in), .reset_in(reset_in),
		.conv_start_in(conv_start_out), .conv_channel_in(conv_channel_out),
		.conv_done_out(conv_done_in), .conv_result_out(conv_result_in));
	// 25 MHz system clock
	always #20 clk_in = ~clk_in;
	// ------------------------------------------------
	// bus tasks: strobe held to the taking edge, then a free edge
	// ------------------------------------------------
	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic fw(input logic [7:0] a, input logic [7:0] v);
		f_addr_in = a;
		f_wdata_in = v;
		f_wr_in = 1'b1;
		tick(1);
		f_wr_in = 1'b0;
		tick(1);
	endtask : fw
	task automatic rw(input logic [7:0] a, input logic [7:0] v);
		r_addr_in = a;
		r_wdata_in = v;
		r_wr_in = 1'b1;
		tick(1);
		r_wr_in = 1'b0;
		tick(1);
	endtask : rw
	task automatic fr(input logic [7:0] a);
		f_addr_in = a;
		tick(1);
		d = f_rdata_out;
	endtask : fr
	task automatic rst(input logic [13:0] c);
		reset_in = 1'b1;
		config_word_in = c;
		tick(3);
		reset_in = 1'b0;
		tick(2);
	endtask : rst
	// bounded wait for the tone to flip; n holds the clocks taken
	task automatic wchg;
		t = tone_out;
		for (n = 0; n < 100 && tone_out === t; n++) tick(1);
	endtask : wchg
	task automatic chk(input string nm, input logic [11:0] x, input logic [11:0] g);
		n_tests++;
		if (g !== x) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic close_out;
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// hang guard, about twice the expected run
	initial begin
		repeat (60000) @(posedge clk_in);
		fails++;
		close_out();
	end
	// main sequence
	initial begin
		reset_in = 1'b1;
		tick(20);
		reset_in = 1'b0;
		tick(2);
		chk("mask reset", 8'hff, conv_pin_type_mask_out);
		// prescaler phase unknown: allow two steps
		for (k = 0; k <= 8; k++) begin
			rw(8'h02, 8'(k));
			fw(8'h01, 8'h00);
			tick(2046);
			fr(8'h01);
			chk("t0 rate", 1'b1, 8'(d - 8'(1024 >> k) + 8'd2) <= 8'd4);
		end
		rw(8'h02, 8'h00);
		fw(8'h09, 8'h00);
		fw(8'h01, 8'hff);
		tick(4);
		fr(8'h09);
		chk("t0 flag", 1'b1, d[4]);
		rw(8'h0e, 8'h01);
		rw(8'h03, 8'h00);
		chk("sleep", 1'b1, sleep_out);
		fr(8'h01);
		e = d;
		tick(20);
		fr(8'h01);
		chk("frozen", e, d);
		ext_irq_pending_in = 3'b001;
		for (n = 0; n < 10 && sleep_out === 1'b1; n++) tick(1);
		chk("wake", 1'b0, sleep_out);
		ext_irq_pending_in = 3'b000;
		rw(8'h0e, 8'h00);
		rw(8'h02, 8'h10);
		fw(8'h01, 8'h00);
		repeat (5) begin
			first_timer_count_pin_in = 1'b1;
			tick(4);
			first_timer_count_pin_in = 1'b0;
			tick(4);
		end
		fr(8'h01);
		chk("t0 pin", 8'h05, d);
		rw(8'h0d, 8'hf0);
		rw(8'h0c, 8'h00);
		rw(8'h0b, 8'h04);
		fw(8'h09, 8'h00);
		fw(8'h0a, 8'hfe);
		t = second_timer_toggle_out;
		tick(8);
		fr(8'h0a);
		chk("t1 reload", 1'b1, d >= 8'hf0);
		fr(8'h09);
		chk("t1 flag", 1'b1, d[5]);
		chk("t1 out", !t, second_timer_toggle_out);
		rw(8'h0c, 8'h40);
		fw(8'h11, 8'h0d);
		fr(8'h11);
		chk("busy", 1'b1, d[3]);
		for (n = 0; n < 50 && d[3] !== 1'b0; n++) fr(8'h11);
		chk("done", 1'b0, d[3]);
		e = d;
		fr(8'h10);
		chk("result", 12'haa5, {d, e[7:4]});
		chk("channel", 3'd5, conv_channel_out);
		rw(8'h12, 8'h5a);
		chk("mask", 8'h5a, conv_pin_type_mask_out);
		rw(8'h0b, 8'h83);
		rw(8'h10, 8'h01);
		rw(8'h0c, 8'h80);
		wchg();
		wchg();
		chk("tone half", 12'd8, 12'(n));
		rw(8'h0b, 8'h43);
		tick(2);
		chk("tone gated", 1'b0, tone_out);
		fw(8'h0c, 8'h40);
		for (k = 0; k < 4; k++) begin
			fw(8'h0d, 8'(k << 6));
			tick(1100);
			n = 0;
			repeat (1024) begin
				tick(1);
				n += int'(pwm0_out);
			end
			chk("pwm high", 12'(252 + k), 12'(n));
		end
		rst(14'h0040);
		for (n = 0; n < 200 && chip_reset_out !== 1'b1; n++) tick(1);
		chk("dog span", 1'b1, n >= 44 && n <= 56);
		rst(14'h0000);
		rw(8'h0e, 8'h08);
		tick(70);
		fr(8'h09);
		chk("wake flag", 1'b1, d[3]);
		chk("no reset", 1'b0, chip_reset_out);
		chk("irq", 1'b1, irq_out);
		rst(14'h0080);
		ext_reset_pin_n_in = 1'b0;
		tick(8);
		chk("pin reset", 1'b1, chip_reset_out);
		ext_reset_pin_n_in = 1'b1;
		rst(14'h0800);
		chk("lvr bad", 1'b1, lvr_invalid_out);
		chk("lvr off", 1'b0, lvr_enable_out);
		rst(14'h0c00);
		chk("lvr on", 1'b1, lvr_enable_out);
		chk("lvr low", 1'b0, lvr_level_sel_out);
		close_out();
	end
endmodule : testbench
`default_nettype wire
